// ### eebpm_pkg.sv
// Constants, encodings and helpers for the block map and protection logic.
// Assumes a single 25 MHz clock domain; no timing figures are needed here.
package eebpm_pkg;
  localparam int NUM_BLOCKS = 18;
  localparam int MEM_DEPTH = 144;
  localparam int MEM_AW = 8;
  localparam int CNT_W = 16;
  localparam logic [4:0] USER_LAST_BLK = 5'h0F;
  localparam logic [4:0] PARAM_BLK = 5'h10;
  localparam logic [4:0] CTRL_BLK = 5'h11;
  localparam logic [7:0] CODE_UNLOCKED = 8'h00;
  localparam logic [7:0] CODE_EPROM = 8'h0A;
  localparam logic [7:0] CODE_LOCKED = 8'hAA;
  localparam logic [3:0] NIBBLE_WP = 4'hA;
  localparam logic [7:0] MEM_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] FIELD_LAST = 3'h3;
  localparam logic [2:0] BYTE_AFI = 3'h4;
  localparam logic [2:0] BYTE_U1 = 3'h5;
  localparam logic [2:0] LOCK_FIELD = 3'h4;
  localparam logic [2:0] LOCK_AFI = 3'h5;
  localparam logic [2:0] LOCK_U1 = 3'h6;
  localparam logic [2:0] LOCK_SELF = 3'h7;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  localparam logic [3:0] DATA_COUNT = 4'h8;
  localparam logic [3:0] CUSTOM_COUNT = 4'hA;
  localparam logic [3:0] CNT_LO_IDX = 4'h8;

  // Byte address of byte i of a block: block number times eight plus i
  function automatic logic [7:0] byte_addr(input logic [4:0] blk, input logic [2:0] i);
    return {blk, i};
  endfunction

  // Write-cycle count after one more write, holding at the top value
  function automatic logic [15:0] cnt_next(input logic [15:0] c);
    return (c == CNT_MAX) ? c : c + 16'h0001;
  endfunction
endpackage

// ### eebpm_store_if.sv
// Carrier between the controller and its byte store and counter bank.
// Assumes all three ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface eebpm_store_if;
  logic [7:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [4:0] cnt_blk;
  logic cnt_inc;
  logic [15:0] cnt_rdata;
  modport ctrl (output mem_addr, mem_we, mem_wdata, cnt_blk, cnt_inc,
                input mem_rdata, cnt_rdata);
  modport mem (input mem_addr, mem_we, mem_wdata, output mem_rdata);
  modport cnt (input cnt_blk, cnt_inc, output cnt_rdata);
endinterface
`default_nettype wire

// ### eebpm_mem.sv
// Byte-wide store standing in for the nonvolatile array, registered read.
// Assumes reads and writes come from one controller; no reset, like the array.
`timescale 1ns/10ps
`default_nettype none
module eebpm_mem #(
  parameter int DEPTH = 144,
  parameter int AW = 8
) (
  input wire logic clk,
  eebpm_store_if.mem st
);
  import eebpm_pkg::*;
  // Array must be addressable with the given width
  if (DEPTH > (1 << AW) || DEPTH < 1)
  begin : g_chk
    $error("eebpm_mem depth does not fit address width");
  end
  // Factory state of the array; set at declaration so the write process is its only driver
  logic [7:0] mem [DEPTH] = '{default: MEM_RESET};
  // Write port; out of range writes are dropped
  always_ff @(posedge clk)
  begin
    if (st.mem_we && int'(st.mem_addr) < DEPTH)
      mem[st.mem_addr] <= st.mem_wdata;
  end
  // Registered read; out of range reads return zero
  always_ff @(posedge clk)
  begin
    st.mem_rdata <= (int'(st.mem_addr) < DEPTH) ? mem[st.mem_addr] : MEM_RESET;
  end
endmodule
`default_nettype wire

// ### eebpm_wcc.sv
// Per-block write-cycle counters, one 16-bit word per block.
// Assumes the controller pulses cnt_inc once per accepted block write.
`timescale 1ns/10ps
`default_nettype none
module eebpm_wcc #(
  parameter int BLOCKS = 18
) (
  input wire logic clk,
  input wire logic arst_n,
  eebpm_store_if.cnt st
);
  import eebpm_pkg::*;
  if (BLOCKS < 1 || BLOCKS > 32)
  begin : g_chk
    $error("eebpm_wcc block count must be 1 to 32");
  end
  // Counters are nonvolatile, so reset does not touch them; zero at power-up only
  logic [15:0] cnt [BLOCKS] = '{default: CNT_RESET};
  // Advance on a write, saturating at the top value
  always_ff @(posedge clk)
  begin
    if (st.cnt_inc && int'(st.cnt_blk) < BLOCKS)
      cnt[st.cnt_blk] <= cnt_next(cnt[st.cnt_blk]);
  end
  // Registered read of the addressed block's count
  always_ff @(posedge clk)
  begin
    st.cnt_rdata <= (int'(st.cnt_blk) < BLOCKS) ? cnt[st.cnt_blk] : CNT_RESET;
  end
  property p_saturate;
    @(posedge clk) disable iff (!arst_n)
    (st.cnt_inc && st.cnt_rdata == CNT_MAX && !$changed(st.cnt_blk)) |=> ##1
    (st.cnt_rdata == CNT_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("count left its top value");
endmodule
`default_nettype wire

// ### eebpm_top.sv
// Block map, protection and write-cycle counting for the fob memory.
// Assumes the command interpreter streams block bytes one per cycle.
`timescale 1ns/10ps
`default_nettype none
module eebpm_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_custom,
  input wire logic [4:0] req_block,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic done,
  output logic refused
);
  import eebpm_pkg::*;

  // Controller phases
  typedef enum logic [2:0] {
    S_LOAD, S_IDLE, S_COLLECT, S_FETCH, S_DECIDE, S_COMMIT, S_READ, S_FINISH
  } eebpm_state_t;

  eebpm_state_t st_q; // Current phase
  logic [3:0] idx_q; // Byte index of the phase
  logic pend_q; // A read issued last cycle
  logic [3:0] pidx_q; // Index of that read
  logic [4:0] blk_q; // Block of the request
  logic custom_q; // Request wants the counter too
  logic refused_q; // Outcome of the last request
  logic rd_valid_q; // Read byte on rd_byte_q
  logic [7:0] rd_byte_q; // Read byte
  logic [7:0] buf_q [8]; // Incoming write bytes
  logic [7:0] old_q [8]; // Stored bytes before the write
  logic [7:0] prot_q [8]; // Shadow of block 11h
  logic [7:0] final_c [8]; // Bytes to be written
  logic refuse_c; // Write must be refused
  logic [3:0] lim_c; // Reads issued in this phase
  logic issue_c; // A store read this cycle
  logic [4:0] addr_blk_c; // Block the store is addressed in
  logic accept_c; // Request taken this cycle
  logic last_wr_c; // Last byte of a write arrives

  eebpm_store_if sif ();

  // Byte store holding all eighteen blocks
  eebpm_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .clk(clk),
    .st(sif)
  );

  // Hidden write-cycle counters, outside the byte map
  eebpm_wcc #(
    .BLOCKS(NUM_BLOCKS)
  ) u_wcc (
    .clk(clk),
    .arst_n(arst_n),
    .st(sif)
  );

  assign req_ready = (st_q == S_IDLE); // Closed while reloading
  assign accept_c = req_valid && req_ready;
  assign last_wr_c = (st_q == S_COLLECT) && wr_valid && (idx_q[2:0] == LAST_BYTE);
  assign done = (st_q == S_FINISH);
  assign refused = refused_q;
  assign rd_valid = rd_valid_q;
  assign rd_byte = rd_byte_q;

  // Custom reads run two bytes past the data
  assign lim_c = (st_q == S_READ && custom_q) ? CUSTOM_COUNT : DATA_COUNT;
  assign issue_c = (st_q == S_LOAD || st_q == S_FETCH || st_q == S_READ) && (idx_q < lim_c);
  // Reload always looks at the control block
  assign addr_blk_c = (st_q == S_LOAD) ? CTRL_BLK : blk_q;

  // Store port; bytes go in index order, byte 0 first
  assign sif.mem_addr = byte_addr(addr_blk_c, idx_q[2:0]);
  assign sif.mem_we = (st_q == S_COMMIT);
  assign sif.mem_wdata = final_c[idx_q[2:0]];
  assign sif.cnt_blk = blk_q;
  // One count per written block, with the last byte
  assign sif.cnt_inc = (st_q == S_COMMIT) && (idx_q[2:0] == LAST_BYTE);

  // Page code transition check: the EPROM code never changes, protect codes only gain bits
  function automatic logic page_code_ok(input logic [7:0] old, input logic [7:0] nw);
    if (old == CODE_EPROM)
      return nw == old;
    if (old[7:4] == NIBBLE_WP)
      return (nw[7:4] == NIBBLE_WP) && ((nw[3:0] & old[3:0]) == old[3:0]);
    return 1'b1;
  endfunction

  // Protection decision and merged data for a pending write
  always_comb
  begin
    logic [7:0] code;
    logic lock;
    code = prot_q[blk_q[3:2]]; // Page is block over four
    lock = 1'b0;
    refuse_c = (blk_q > CTRL_BLK); // Unmapped block
    // Per-block write protection in its page
    if (blk_q <= USER_LAST_BLK && code[7:4] == NIBBLE_WP && code[blk_q[1:0]])
      refuse_c = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      final_c[i] = buf_q[i];
      if (blk_q <= USER_LAST_BLK)
      begin
        // User area; emulated EPROM bits can only be cleared
        if (code == CODE_EPROM)
          final_c[i] = old_q[i] & buf_q[i];
      end
      else if (blk_q == PARAM_BLK)
      begin
        // Field, family id and first user byte locks; others free
        lock = (i <= int'(FIELD_LAST) && prot_q[LOCK_FIELD] == CODE_LOCKED)
            || (i == int'(BYTE_AFI) && prot_q[LOCK_AFI] == CODE_LOCKED)
            || (i == int'(BYTE_U1) && prot_q[LOCK_U1] == CODE_LOCKED);
        if (lock && buf_q[i] != old_q[i])
          refuse_c = 1'b1;
      end
      else if (blk_q == CTRL_BLK)
      begin
        if (i < 4)
        begin
          if (!page_code_ok(old_q[i], buf_q[i]))
            refuse_c = 1'b1;
        end
        else if (old_q[i] == CODE_LOCKED && buf_q[i] != old_q[i])
          refuse_c = 1'b1; // Each lock, self lock included, guards itself
      end
    end
  end

  // Phase sequencing
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= S_LOAD; // Re-read protection before serving anyone
    else
    begin
      unique case (st_q)
        S_LOAD:
          if (idx_q == DATA_COUNT && !pend_q)
            st_q <= S_IDLE;
        S_IDLE:
          if (accept_c)
          begin
            if (req_write)
              st_q <= S_COLLECT;
            else if (req_block > CTRL_BLK)
              st_q <= S_FINISH;
            else
              st_q <= S_READ;
          end
        S_COLLECT:
          if (last_wr_c)
            st_q <= S_FETCH;
        S_FETCH:
          if (idx_q == DATA_COUNT && !pend_q)
            st_q <= S_DECIDE;
        S_DECIDE:
          st_q <= refuse_c ? S_FINISH : S_COMMIT; // Refused writes store nothing
        S_COMMIT:
          if (idx_q[2:0] == LAST_BYTE)
            st_q <= S_FINISH;
        S_READ:
          if (idx_q == lim_c && !pend_q)
            st_q <= S_FINISH;
        S_FINISH:
          st_q <= S_IDLE;
      endcase
    end
  end

  // Byte index; cleared in S_IDLE, in S_DECIDE and on the last write byte
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      idx_q <= 4'h0;
    else if (st_q == S_IDLE || st_q == S_DECIDE || last_wr_c)
      idx_q <= 4'h0;
    else if (issue_c || st_q == S_COMMIT || (st_q == S_COLLECT && wr_valid))
      idx_q <= idx_q + 4'h1;
  end

  // Track the one-cycle store read latency
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_q <= 1'b0;
      pidx_q <= 4'h0;
    end
    else
    begin
      pend_q <= issue_c;
      pidx_q <= idx_q;
    end
  end

  // Request capture and outcome
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blk_q <= 5'h00;
      custom_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else if (accept_c)
    begin
      blk_q <= req_block;
      custom_q <= req_custom && !req_write;
      refused_q <= !req_write && (req_block > CTRL_BLK);
    end
    else if (st_q == S_DECIDE)
      refused_q <= refuse_c;
  end

  // Write bytes arrive byte 0 first
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        buf_q[i] <= MEM_RESET;
    end
    else if (st_q == S_COLLECT && wr_valid)
      buf_q[idx_q[2:0]] <= wr_byte;
  end

  // Old contents, needed for lock compares and EPROM merging
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        old_q[i] <= MEM_RESET;
    end
    else if (st_q == S_FETCH && pend_q)
      old_q[pidx_q[2:0]] <= sif.mem_rdata;
  end

  // Protection shadow: loaded after reset, kept in step with writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        prot_q[i] <= CODE_UNLOCKED;
    end
    else if (st_q == S_LOAD && pend_q)
      prot_q[pidx_q[2:0]] <= sif.mem_rdata;
    else if (st_q == S_COMMIT && blk_q == CTRL_BLK)
      prot_q[idx_q[2:0]] <= final_c[idx_q[2:0]];
  end

  // Read stream: eight data bytes, then count low and high
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_valid_q <= 1'b0;
      rd_byte_q <= MEM_RESET;
    end
    else
    begin
      rd_valid_q <= (st_q == S_READ) && pend_q;
      if (pidx_q < CNT_LO_IDX)
        rd_byte_q <= sif.mem_rdata;
      else if (pidx_q == CNT_LO_IDX)
        rd_byte_q <= sif.cnt_rdata[7:0];
      else
        rd_byte_q <= sif.cnt_rdata[15:8];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_rd_take;
    accept_c && !req_write && !req_custom && req_block <= CTRL_BLK;
  endsequence
  sequence s_cust_take;
    accept_c && !req_write && req_custom && req_block <= CTRL_BLK;
  endsequence
  sequence s_data_burst;
    rd_valid[*8];
  endsequence

  property p_load_closed;
    (st_q == S_LOAD) |-> !req_ready ##[1:10] req_ready;
  endproperty
  a_load_closed: assert property (p_load_closed) else $error("ready while reloading");

  property p_read;
    s_rd_take |=> ##2 s_data_burst ##1 (!rd_valid && done);
  endproperty
  a_read: assert property (p_read) else $error("plain read not eight bytes");

  property p_custom;
    s_cust_take |=> ##2 s_data_burst ##1 rd_valid[*2] ##1 (!rd_valid && done);
  endproperty
  a_custom: assert property (p_custom) else $error("custom read not ten bytes");

  property p_refuse;
    (st_q == S_DECIDE && refuse_c) |=> (done && refused && !sif.mem_we && !sif.cnt_inc);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused write touched store");

  property p_wp_block;
    (st_q == S_DECIDE && blk_q <= USER_LAST_BLK && prot_q[blk_q[3:2]][7:4] == NIBBLE_WP
      && prot_q[blk_q[3:2]][blk_q[1:0]]) |=> (done && refused);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected block written");

  property p_eprom_sticky;
    (prot_q[1] == CODE_EPROM && st_q != S_LOAD) |=> (prot_q[1] == CODE_EPROM);
  endproperty
  a_eprom_sticky: assert property (p_eprom_sticky) else $error("page code left EPROM");

  property p_self_sticky;
    (prot_q[LOCK_SELF] == CODE_LOCKED && st_q != S_LOAD) |=>
    (prot_q[LOCK_SELF] == CODE_LOCKED);
  endproperty
  a_self_sticky: assert property (p_self_sticky) else $error("self lock reopened");

  property p_wp_bits;
    (prot_q[0][7:4] == NIBBLE_WP && st_q != S_LOAD) |=>
    ((prot_q[0] | $past(prot_q[0])) == prot_q[0]) && (prot_q[0][7:4] == NIBBLE_WP);
  endproperty
  a_wp_bits: assert property (p_wp_bits) else $error("protect bit cleared");

  property p_inc_once;
    sif.cnt_inc |-> (st_q == S_COMMIT && !refused_q) ##1 (done && !sif.cnt_inc);
  endproperty
  a_inc_once: assert property (p_inc_once) else $error("bad counter advance");
endmodule
`default_nettype wire

// ### eebpm_host_model.sv
// Stand-in for the command interpreter that feeds block requests to the block.
// Assumes the request handshake, byte strobes and done pulse of the top module.
`timescale 1ns/10ps
`default_nettype none
module eebpm_host_model (
  input wire logic clk,
  output logic req_valid,
  input wire logic req_ready,
  output logic req_write,
  output logic req_custom,
  output logic [4:0] req_block,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic done,
  input wire logic refused
);
  localparam int WAIT_MAX = 100; // Longest request takes 28 cycles
  logic [7:0] rx [0:9]; // Returned bytes: eight data, then the count
  int rx_n; // Number of bytes returned so far
  // Idle at time zero; req_custom and req_block are inverted once released, req_write is left as driven
  initial
  begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_custom = 1'b0;
    req_block = 5'h00;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    rx_n = 0;
  end
  // Collect every returned byte in arrival order
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1 && rx_n < 10)
    begin
      rx[rx_n] = rd_byte;
      rx_n++;
    end
  end
  // Hold the request until an edge sees ready, then release it
  task automatic issue(input logic wr, input logic cu, input logic [4:0] blk);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_custom = cu;
    req_block = blk;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < WAIT_MAX)
    begin
      n++;
      @(posedge clk);
    end
    #1;
    req_valid = 1'b0;
    req_custom = ~cu;
    req_block = ~blk;
  endtask
  // Wait a bounded time for done, then take the standing outcome
  task automatic finish(output logic ref_o);
    int n;
    n = 0;
    @(posedge clk);
    while (done !== 1'b1 && n < WAIT_MAX)
    begin
      n++;
      @(posedge clk);
    end
    #1;
    ref_o = refused;
  endtask
  // Write one block: eight strobed bytes with no gaps
  task automatic write_blk(input logic [4:0] blk, input logic [63:0] d, output logic ref_o);
    issue(1'b1, 1'b0, blk);
    for (int i = 0; i < 8; i++)
    begin
      wr_valid = 1'b1;
      wr_byte = d[8*i +: 8]; // Byte 0 leaves first
      @(posedge clk);
      #1;
    end
    wr_valid = 1'b0;
    wr_byte = ~wr_byte;
    finish(ref_o);
  endtask
  // Read one block; a custom read also yields the write count
  task automatic read_blk(input logic [4:0] blk, input logic cu, output logic [63:0] d,
                          output logic [15:0] cnt, output logic ref_o, output int n);
    rx_n = 0;
    issue(1'b0, cu, blk);
    finish(ref_o);
    for (int i = 0; i < 8; i++)
    begin
      d[8*i +: 8] = rx[i]; // First byte in is byte 0
    end
    cnt = {rx[9], rx[8]}; // Low byte arrives first
    n = rx_n;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the block map and protection logic.
// Assumes memory and counters start at zero and survive a reset.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import eebpm_pkg::*;
  logic clk;
  logic arst_n;
  wire logic req_valid, req_ready, req_write, req_custom, wr_valid;
  wire logic rd_valid, done, refused;
  wire logic [4:0] req_block;
  wire logic [7:0] wr_byte, rd_byte;
  int fails = 0; // Mismatches seen
  int n_checks = 0; // Comparisons made
  int cycles = 0; // Guard against a hang
  logic r; // Outcome of the last request
  logic [63:0] d; // Data of the last read
  logic [15:0] c; // Count of the last read
  int n; // Bytes returned by the last read
  logic [63:0] ctl; // Expected contents of the control block
  logic [63:0] v10; // Expected contents of the parameter block
  always #20 clk = ~clk;
  eebpm_top eebpm_top_inst (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_custom(req_custom),
    .req_block(req_block), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .done(done), .refused(refused));
  eebpm_host_model eebpm_host_model_inst (.clk(clk), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_custom(req_custom),
    .req_block(req_block), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .done(done), .refused(refused));
  // Compare and count; report at once on a difference
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Single place where the run ends
  task automatic stop_test;
    $display("TB: checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Write a block and compare the outcome
  task automatic wr(input logic [4:0] b, input logic [63:0] v, input logic e);
    eebpm_host_model_inst.write_blk(b, v, r);
    check(r, e);
  endtask
  // Custom read: data, count and byte total all compared
  task automatic rdc(input logic [4:0] b, input logic [63:0] v, input logic [15:0] k);
    eebpm_host_model_inst.read_blk(b, 1'b1, d, c, r, n);
    check(d, v);
    check(c, k);
    check(64'(n), 64'hA);
  endtask
  // Cut a hang short; the full run needs well under this many cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    ctl = 64'h0;
    v10 = 64'hC3B2A144DDCCBBAA;
    repeat (16) @(posedge clk);
    check(req_ready, 1'b0);
    #1;
    arst_n = 1'b1;
    // Map: plain read gives eight bytes, unmapped block is refused
    eebpm_host_model_inst.read_blk(5'h00, 1'b0, d, c, r, n);
    check(64'(n), 64'h8);
    check(d, 64'h0);
    eebpm_host_model_inst.read_blk(5'h12, 1'b0, d, c, r, n);
    check(r, 1'b1);
    check(64'(n), 64'h0);
    wr(5'h13, 64'h13, 1'b1);
    $display("TB: test map done");
    // Byte order and counting on a user block
    wr(5'h00, 64'h0706050403020100, 1'b0);
    wr(5'h00, 64'h8877665544332211, 1'b0);
    rdc(5'h00, 64'h8877665544332211, 16'h0002);
    rdc(5'h0F, 64'h0, 16'h0000);
    $display("TB: test counter done");
    // Per-block write protection in page 0
    ctl[7:0] = 8'hA2;
    wr(5'h11, ctl, 1'b0);
    wr(5'h01, 64'h1, 1'b1);
    rdc(5'h01, 64'h0, 16'h0000);
    wr(5'h02, 64'h2, 1'b0);
    wr(5'h05, 64'h5, 1'b0);
    wr(5'h11, {ctl[63:8], 8'hA0}, 1'b1);
    wr(5'h11, {ctl[63:8], 8'hB2}, 1'b1);
    ctl[7:0] = 8'hA6;
    wr(5'h11, ctl, 1'b0);
    wr(5'h02, 64'h3, 1'b1);
    $display("TB: test write protect done");
    // EPROM emulation on page 1: bits only clear; block 04h is seeded while still open
    wr(5'h04, 64'hFF00FF00F0F0F0F0, 1'b0);
    ctl[15:8] = 8'h0A;
    wr(5'h11, ctl, 1'b0);
    wr(5'h04, 64'h0FF00FF0FFFF0000, 1'b0);
    rdc(5'h04, 64'h0F000F00F0F00000, 16'h0002);
    wr(5'h11, {ctl[63:16], 8'h00, ctl[7:0]}, 1'b1);
    $display("TB: test emulation done");
    // Lock bytes guarding the parameter block
    wr(5'h10, v10, 1'b0);
    ctl[39:32] = 8'hAA;
    wr(5'h11, ctl, 1'b0);
    wr(5'h10, v10 ^ 64'h1, 1'b1);
    v10 = v10 ^ 64'hFFFFFF0000000000;
    wr(5'h10, v10, 1'b0);
    rdc(5'h10, v10, 16'h0002);
    ctl[47:40] = 8'h55;
    wr(5'h11, ctl, 1'b0);
    v10[39:32] = 8'h45;
    wr(5'h10, v10, 1'b0);
    ctl[55:48] = 8'hAA;
    wr(5'h11, ctl, 1'b0);
    wr(5'h10, {v10[63:48], 8'h00, v10[39:0]}, 1'b1);
    wr(5'h11, {ctl[63:40], 8'h00, ctl[31:0]}, 1'b1);
    $display("TB: test locks done");
    // Self lock guards only itself
    ctl[63:56] = 8'hAA;
    wr(5'h11, ctl, 1'b0);
    wr(5'h11, {8'h00, ctl[55:0]}, 1'b1);
    ctl[31:24] = 8'hA1;
    wr(5'h11, ctl, 1'b0);
    wr(5'h0C, 64'hC, 1'b1);
    $display("TB: test self lock done");
    // Second reset: protection reloaded, contents kept
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    wr(5'h01, 64'h9, 1'b1);
    wr(5'h0C, 64'hD, 1'b1);
    rdc(5'h04, 64'h0F000F00F0F00000, 16'h0002);
    eebpm_host_model_inst.read_blk(5'h11, 1'b0, d, c, r, n);
    check(d, ctl);
    $display("TB: test reset reload done");
    stop_test();
  end
endmodule
`default_nettype wire
